// [dv/tb.sv]
`timescale 1ns/10ps
`include "tcw_defines.svh"
module tb;
   // ****************
   // Bench
   // ****************
   logic clk = 1'b0;
   logic nrst = 1'b1;
   logic tk = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wd = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic [1:0] pv, oe, lvl;
   logic [2:0] fl;
   int bad_count = 0;
   int n_compared = 0;
   always #4 clk = ~clk;
   tcw_top uut (.I_SYS_CLK(clk), .I_NRST(nrst), .I_TIMER_TICK(tk),
      .I_ADDR(addr), .I_WDATA(wd), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
      .O_PIN_VAL(pv), .O_PIN_OE(oe), .O_FLAGS(fl));
   tcw_pin_load load (.i_val(pv), .i_oe(oe), .o_level(lvl));
   task final_report;
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task w(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : w
   task ex(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask : ex
   task pin(input logic [1:0] e);
      repeat (2) @(posedge clk);
      #1 chk({6'h00, lvl}, {6'h00, e});
   endtask : pin
   task tick(input int n);
      repeat (n) begin
         @(posedge clk);
         tk <= 1'b1;
      end
      @(posedge clk);
      tk <= 1'b0;
   endtask : tick
   initial begin
      #50000;
      bad_count++;
      final_report;
   end
   initial begin
      nrst <= 1'b0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      w(`TCW_ADDR_CTRL_A, 8'hF0);
      w(`TCW_ADDR_CTRL_B, 8'h40);
      w(`TCW_ADDR_DIR, 8'h03);
      pin(2'h2);
      w(`TCW_ADDR_PORT, 8'h01);
      pin(2'h2);
      ex(`TCW_ADDR_FLAGS, 8'h00);
      ex(`TCW_ADDR_COUNT, 8'h00);
      w(`TCW_ADDR_CTRL_B, 8'h80);
      pin(2'h3);
      w(`TCW_ADDR_PORT, 8'h00);
      w(`TCW_ADDR_CTRL_A, 8'h00);
      pin(2'h0);
      w(`TCW_ADDR_CTRL_A, 8'h82);
      pin(2'h1);
      w(`TCW_ADDR_CTRL_A, 8'h00);
      w(`TCW_ADDR_COUNT, 8'hFE);
      tick(1);
      ex(`TCW_ADDR_COUNT, 8'hFF);
      ex(`TCW_ADDR_FLAGS, 8'h00);
      tick(1);
      ex(`TCW_ADDR_COUNT, 8'h00);
      ex(`TCW_ADDR_FLAGS, 8'h01);
      chk({5'h00, fl}, 8'h01);
      w(`TCW_ADDR_FLAGS, 8'h01);
      ex(`TCW_ADDR_FLAGS, 8'h00);
      w(`TCW_ADDR_CMP_A, 8'h10);
      w(`TCW_ADDR_CTRL_A, 8'h40);
      w(`TCW_ADDR_COUNT, 8'h10);
      tick(3);
      ex(`TCW_ADDR_FLAGS, 8'h00);
      pin(2'h1);
      w(`TCW_ADDR_COUNT, 8'h0F);
      tick(3);
      ex(`TCW_ADDR_FLAGS, 8'h02);
      pin(2'h0);
      w(`TCW_ADDR_FLAGS, 8'h02);
      ex(`TCW_ADDR_FLAGS, 8'h00);
      w(`TCW_ADDR_CMP_A, 8'h03);
      w(`TCW_ADDR_CTRL_A, 8'h42);
      w(`TCW_ADDR_COUNT, 8'h00);
      tick(4);
      ex(`TCW_ADDR_COUNT, 8'h00);
      pin(2'h1);
      w(`TCW_ADDR_CMP_A, 8'h05);
      w(`TCW_ADDR_COUNT, 8'h00);
      tick(3);
      w(`TCW_ADDR_FLAGS, 8'h07);
      w(`TCW_ADDR_CMP_A, 8'h01);
      tick(253);
      ex(`TCW_ADDR_COUNT, 8'h00);
      ex(`TCW_ADDR_FLAGS, 8'h01);
      w(`TCW_ADDR_FLAGS, 8'h07);
      w(`TCW_ADDR_CTRL_A, 8'h83);
      w(`TCW_ADDR_CMP_A, 8'h80);
      w(`TCW_ADDR_COUNT, 8'h00);
      tick(2);
      pin(2'h0);
      ex(`TCW_ADDR_CMP_A, 8'h80);
      tick(254);
      pin(2'h1);
      ex(`TCW_ADDR_FLAGS, 8'h03);
      chk({5'h00, fl}, 8'h03);
      ex(`TCW_ADDR_COUNT, 8'h00);
      tick(129);
      pin(2'h0);
      w(`TCW_ADDR_CTRL_A, 8'hC3);
      tick(256);
      pin(2'h1);
      w(`TCW_ADDR_CTRL_B, 8'h04);
      w(`TCW_ADDR_CTRL_A, 8'h43);
      w(`TCW_ADDR_CMP_A, 8'h04);
      w(`TCW_ADDR_COUNT, 8'h7F);
      tick(2);
      pin(2'h0);
      tick(5);
      ex(`TCW_ADDR_COUNT, 8'h00);
      pin(2'h1);
      final_report;
   end
endmodule : tb

// [dv/tcw_pin_load.sv]
`timescale 1ns/10ps
module tcw_pin_load (
   input wire logic [1:0] i_val,
   input wire logic [1:0] i_oe,
   output logic [1:0] o_level
);
   // ****************
   // Pull-down load
   // ****************
   assign o_level = i_val & i_oe;
endmodule : tcw_pin_load

// [dv/tcw_top_assertions.sv]
`timescale 1ns/10ps
`include "tcw_defines.svh"
module tcw_top_chk (
   input wire logic I_SYS_CLK,
   input wire logic I_NRST,
   input wire logic I_TIMER_TICK,
   input wire logic [3:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   input wire logic [7:0] O_RDATA,
   input wire logic [1:0] O_PIN_VAL,
   input wire logic [1:0] O_PIN_OE,
   input wire logic [2:0] O_FLAGS
);
   // ****************
   // Port checks
   // ****************
   logic quiet;
   logic dir_wr;
   logic ovf_clr;
   logic cmp_clr;
   logic [1:0] wd_lo;
   assign quiet = !I_TIMER_TICK && !I_WR;
   assign dir_wr = I_WR && I_ADDR == `TCW_ADDR_DIR;
   assign ovf_clr = I_WR && I_ADDR == `TCW_ADDR_FLAGS && I_WDATA[0];
   assign cmp_clr = I_WR && I_ADDR == `TCW_ADDR_FLAGS && I_WDATA[1];
   assign wd_lo = I_WDATA[1:0];
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_NRST);
   rst_outputs_a: assert property (disable iff (1'b0) !I_NRST |->
      O_PIN_VAL == 2'h0 && O_PIN_OE == 2'h0 && O_FLAGS == 3'h0)
      else $error("outputs not cleared in reset");
   oe_follow_a: assert property (dir_wr |-> ##2 O_PIN_OE ==
      $past(wd_lo, 2)) else $error("pin enable not from direction");
   oe_hold_a: assert property (!dir_wr |-> ##2 $stable(O_PIN_OE))
      else $error("pin enable moved without direction write");
   pin_hold_a: assert property (quiet |-> ##2 $stable(O_PIN_VAL))
      else $error("pin moved without tick or write");
   flag_hold_a: assert property (quiet |-> ##2 $stable(O_FLAGS))
      else $error("flags moved without tick or write");
   ovf_clear_a: assert property (ovf_clr && !I_TIMER_TICK
      |-> ##2 !O_FLAGS[0]) else $error("overflow not cleared");
   ovf_fall_a: assert property ($fell(O_FLAGS[0]) |->
      $past(ovf_clr, 2)) else $error("overflow cleared by hardware");
   cmp_clear_a: assert property (cmp_clr && !I_TIMER_TICK
      |-> ##2 !O_FLAGS[1]) else $error("compare flag not cleared");
   cmp_fall_a: assert property ($fell(O_FLAGS[1]) |->
      $past(cmp_clr, 2)) else $error("compare flag fell alone");
endmodule : tcw_top_chk
bind tcw_top tcw_top_chk u_chk (.I_SYS_CLK, .I_NRST, .I_TIMER_TICK,
   .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .O_PIN_VAL, .O_PIN_OE,
   .O_FLAGS);

// [inc/tcw_defines.svh]
`ifndef TCW_DEFINES_SVH
`define TCW_DEFINES_SVH
// ****************************************
// Register offsets
// ****************************************
`define TCW_ADDR_COUNT 4'h0
`define TCW_ADDR_CMP_A 4'h1
`define TCW_ADDR_CMP_B 4'h2
`define TCW_ADDR_CTRL_A 4'h3
`define TCW_ADDR_CTRL_B 4'h4
`define TCW_ADDR_FLAGS 4'h5
`define TCW_ADDR_PORT 4'h6
`define TCW_ADDR_DIR 4'h7
// ****************************************
// Field positions
// ****************************************
`define TCW_FLAG_OVF 0
`define TCW_FLAG_CMP_A 1
`define TCW_FLAG_CMP_B 2
// ****************************************
// Values
// ****************************************
`define TCW_RST_BYTE 8'h00
`define TCW_COUNT_MAX 8'hFF
`define TCW_COUNT_ZERO 8'h00
`define TCW_COUNT_ONE 8'h01
`define TCW_MODE_NORMAL 3'h0
`define TCW_MODE_CTC 3'h2
`define TCW_MODE_FAST_MAX 3'h3
`define TCW_MODE_FAST_CMP 3'h7
`define TCW_ACT_OFF 2'h0
`define TCW_ACT_TOGGLE 2'h1
`define TCW_ACT_CLEAR 2'h2
`define TCW_ACT_SET 2'h3
`endif

// [inc/tcw_pkg.sv]
package tcw_pkg;
   typedef logic [2:0] tcw_mode_t;
   typedef logic [1:0] tcw_act_t;
   // Control byte A: actions and low mode bits
   typedef struct packed {
      tcw_act_t act_a;
      tcw_act_t act_b;
      logic [1:0] unused;
      logic [1:0] mode_lo;
   } tcw_ctrl_a_s;
   // Control byte B: force strobes and high mode bit
   typedef struct packed {
      logic force_a;
      logic force_b;
      logic [2:0] unused;
      logic mode_hi;
      logic [1:0] spare;
   } tcw_ctrl_b_s;
endpackage : tcw_pkg

// [rtl/tcw_top.sv]
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "tcw_defines.svh"
module tcw_top (
   input wire logic I_SYS_CLK,
   input wire logic I_NRST,
   input wire logic I_TIMER_TICK,
   input wire logic [3:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [7:0] O_RDATA,
   output logic [1:0] O_PIN_VAL,
   output logic [1:0] O_PIN_OE,
   output logic [2:0] O_FLAGS
);

   // ****************************************
   // Storage
   // ****************************************
   logic [7:0] count_reg;
   logic [7:0] ocr_act_reg [2];
   logic [7:0] ocr_buf_reg [2];
   logic [1:0] wave_reg;
   logic [1:0] pend_reg;
   logic [1:0] cflag_reg;
   logic ovf_reg;
   logic block_reg;
   tcw_pkg::tcw_ctrl_a_s ctrl_a_reg;
   logic mode_hi_reg;
   logic [1:0] port_reg;
   logic [1:0] dir_reg;
   logic [7:0] rdata_reg;
   logic [1:0] pin_val_reg;
   logic [1:0] pin_oe_reg;

   // ****************************************
   // Decode
   // ****************************************
   tcw_pkg::tcw_mode_t mode;
   tcw_pkg::tcw_ctrl_b_s wr_ctrl_b;
   tcw_pkg::tcw_act_t act [2];
   logic fast;
   logic clear_on_match_mode;
   logic non_pwm;
   logic count_wr;
   logic flags_wr;
   logic ctrl_b_wr;
   logic [7:0] top_val;
   logic at_top;
   logic [1:0] match;
   logic [1:0] force_ev;
   logic [1:0] ocr_wr;
   logic [7:0] count_next;
   logic [7:0] rdata_next;

   // ****************************************
   // Mode decode
   // ****************************************
   assign mode = {mode_hi_reg, ctrl_a_reg.mode_lo};
   assign wr_ctrl_b = I_WDATA;
   assign act[0] = ctrl_a_reg.act_a;
   assign act[1] = ctrl_a_reg.act_b;
   assign fast = (mode == `TCW_MODE_FAST_MAX) ||
                 (mode == `TCW_MODE_FAST_CMP);
   assign clear_on_match_mode = (mode == `TCW_MODE_CTC);
   assign non_pwm = (mode == `TCW_MODE_NORMAL) || clear_on_match_mode;

   // ****************************************
   // Bus decode
   // ****************************************
   assign count_wr = I_WR && (I_ADDR == `TCW_ADDR_COUNT);
   assign flags_wr = I_WR && (I_ADDR == `TCW_ADDR_FLAGS);
   assign ctrl_b_wr = I_WR && (I_ADDR == `TCW_ADDR_CTRL_B);
   assign ocr_wr[0] = I_WR && (I_ADDR == `TCW_ADDR_CMP_A);
   assign ocr_wr[1] = I_WR && (I_ADDR == `TCW_ADDR_CMP_B);

   // ****************************************
   // Compare decode
   // ****************************************
   assign top_val = (mode == `TCW_MODE_FAST_CMP) ? ocr_act_reg[0] :
                    `TCW_COUNT_MAX;
   assign at_top = fast && (count_reg == top_val);
   assign force_ev[0] = ctrl_b_wr && wr_ctrl_b.force_a && non_pwm;
   assign force_ev[1] = ctrl_b_wr && wr_ctrl_b.force_b && non_pwm;

   // ****************************************
   // Action helper
   // ****************************************
   function automatic logic tcw_apply(input logic [1:0] a,
                                      input logic w);
      logic r;
      r = w;
      unique case (a)
         `TCW_ACT_TOGGLE: r = ~w;
         `TCW_ACT_CLEAR: r = 1'b0;
         `TCW_ACT_SET: r = 1'b1;
         default: r = w;
      endcase
      return r;
   endfunction : tcw_apply

   // ****************************************
   // Counter
   // ****************************************
   always_comb begin
      count_next = count_reg;
      if (count_wr) begin
         count_next = I_WDATA;
      end else if (I_TIMER_TICK) begin
         if (at_top) begin
            count_next = `TCW_COUNT_ZERO;
         end else if (clear_on_match_mode && match[0]) begin
            count_next = `TCW_COUNT_ZERO;
         end else begin
            count_next = count_reg + `TCW_COUNT_ONE;
         end
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         count_reg <= `TCW_RST_BYTE;
      end else begin
         count_reg <= count_next;
      end
   end

   // ****************************************
   // Match blocking after a count write
   // ****************************************
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         block_reg <= 1'b0;
      end else if (count_wr) begin
         block_reg <= 1'b1;
      end else if (I_TIMER_TICK) begin
         block_reg <= 1'b0;
      end
   end

   // ****************************************
   // Overflow flag, set wins over clear
   // ****************************************
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         ovf_reg <= 1'b0;
      end else if (I_TIMER_TICK && !count_wr &&
                   (fast ? at_top :
                    (count_reg == `TCW_COUNT_MAX))) begin
         ovf_reg <= 1'b1;
      end else if (flags_wr && I_WDATA[`TCW_FLAG_OVF]) begin
         ovf_reg <= 1'b0;
      end
   end

   // ****************************************
   // Compare channels
   // ****************************************
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_chan
         logic wave_next;
         logic pin_sel;

         assign match[ch] = I_TIMER_TICK && !block_reg && !count_wr &&
                            (count_reg == ocr_act_reg[ch]);

         // ****************************************
         // Buffer always takes the write
         // ****************************************
         always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
            if (!I_NRST) begin
               ocr_buf_reg[ch] <= `TCW_RST_BYTE;
            end else if (ocr_wr[ch]) begin
               ocr_buf_reg[ch] <= I_WDATA;
            end
         end

         // ****************************************
         // Active value: direct or copied at top
         // ****************************************
         always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
            if (!I_NRST) begin
               ocr_act_reg[ch] <= `TCW_RST_BYTE;
            end else if (!fast && ocr_wr[ch]) begin
               ocr_act_reg[ch] <= I_WDATA;
            end else if (fast && I_TIMER_TICK && at_top) begin
               ocr_act_reg[ch] <= ocr_buf_reg[ch];
            end
         end

         // ****************************************
         // Match delayed by one tick
         // ****************************************
         always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
            if (!I_NRST) begin
               pend_reg[ch] <= 1'b0;
            end else if (I_TIMER_TICK) begin
               pend_reg[ch] <= match[ch];
            end
         end

         // ****************************************
         // Compare flag, set wins over clear
         // ****************************************
         always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
            if (!I_NRST) begin
               cflag_reg[ch] <= 1'b0;
            end else if (I_TIMER_TICK && pend_reg[ch]) begin
               cflag_reg[ch] <= 1'b1;
            end else if (flags_wr &&
                         I_WDATA[`TCW_FLAG_CMP_A + ch]) begin
               cflag_reg[ch] <= 1'b0;
            end
         end

         // ****************************************
         // Output latch
         // ****************************************
         always_comb begin
            wave_next = wave_reg[ch];
            if (force_ev[ch]) begin
               wave_next = tcw_apply(act[ch], wave_reg[ch]);
            end else if (I_TIMER_TICK) begin
               if (non_pwm && match[ch]) begin
                  wave_next = tcw_apply(act[ch], wave_reg[ch]);
               end else if (fast) begin
                  if (at_top && act[ch][1]) begin
                     wave_next = (act[ch] == `TCW_ACT_CLEAR);
                  end else if (match[ch] && act[ch][1]) begin
                     wave_next = (act[ch] == `TCW_ACT_SET);
                  end else if (match[ch] && (ch == 0) && mode_hi_reg &&
                               (act[ch] == `TCW_ACT_TOGGLE)) begin
                     wave_next = ~wave_reg[ch];
                  end
               end
            end
         end

         always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
            if (!I_NRST) begin
               wave_reg[ch] <= 1'b0;
            end else begin
               wave_reg[ch] <= wave_next;
            end
         end

         // ****************************************
         // Pin source and direction
         // ****************************************
         assign pin_sel = (act[ch] != `TCW_ACT_OFF) ?
                          wave_reg[ch] : port_reg[ch];

         always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
            if (!I_NRST) begin
               pin_val_reg[ch] <= 1'b0;
               pin_oe_reg[ch] <= 1'b0;
            end else begin
               pin_val_reg[ch] <= pin_sel;
               pin_oe_reg[ch] <= dir_reg[ch];
            end
         end
      end
   endgenerate

   // ****************************************
   // Control registers
   // ****************************************
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         ctrl_a_reg <= `TCW_RST_BYTE;
      end else if (I_WR && (I_ADDR == `TCW_ADDR_CTRL_A)) begin
         ctrl_a_reg <= I_WDATA;
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         mode_hi_reg <= 1'b0;
      end else if (ctrl_b_wr) begin
         mode_hi_reg <= wr_ctrl_b.mode_hi;
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         port_reg <= 2'h0;
      end else if (I_WR && (I_ADDR == `TCW_ADDR_PORT)) begin
         port_reg <= I_WDATA[1:0];
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         dir_reg <= 2'h0;
      end else if (I_WR && (I_ADDR == `TCW_ADDR_DIR)) begin
         dir_reg <= I_WDATA[1:0];
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   always_comb begin
      rdata_next = `TCW_RST_BYTE;
      if (I_RD) begin
         unique case (I_ADDR)
            `TCW_ADDR_COUNT: rdata_next = count_reg;
            `TCW_ADDR_CMP_A: rdata_next = ocr_buf_reg[0];
            `TCW_ADDR_CMP_B: rdata_next = ocr_buf_reg[1];
            `TCW_ADDR_CTRL_A: rdata_next = ctrl_a_reg;
            `TCW_ADDR_CTRL_B: rdata_next = {5'h00, mode_hi_reg, 2'h0};
            `TCW_ADDR_FLAGS: rdata_next = {5'h00, cflag_reg, ovf_reg};
            `TCW_ADDR_PORT: rdata_next = {6'h00, port_reg};
            `TCW_ADDR_DIR: rdata_next = {6'h00, dir_reg};
            default: rdata_next = `TCW_RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         rdata_reg <= `TCW_RST_BYTE;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign O_RDATA = rdata_reg;
   assign O_PIN_VAL = pin_val_reg;
   assign O_PIN_OE = pin_oe_reg;

   // ****************************************
   // Flag copy for the pins
   // ****************************************
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_FLAGS <= 3'h0;
      end else begin
         O_FLAGS <= {cflag_reg, ovf_reg};
      end
   end

endmodule : tcw_top
